// ### hw/cerr_regs.sv
// Correctable error status, mask and control registers with header log for one switch port.
// Assumes all inputs come from logic on the core clock; rst resets everything, hot_rst
// resets only the non-sticky capable bits, which return to one.
//
// Behaviour
// - A physical-layer receiver error sets status bit 0.
// - A bad transaction layer packet sets status bit 6.
// - A bad data link layer packet sets status bit 7.
// - A replay number rollover sets status bit 8.
// - A replay timer expiry sets status bit 12.
// - An advisory non-fatal error sets status bit 13.
// - Status bits reset to zero, clear on a written one, survive hot reset, reserved read zero.
// - A set mask bit stops its event from being reported upstream, and mask bits are sticky.
// - The advisory mask bit resets to one and all other mask bits reset to zero.
// - A sticky read-only 5-bit pointer holds the position of the first uncorrectable error.
// - The generation-capable bit 5 resets to one and is writable only while unlocked.
// - Sticky enable bit 6, reset to zero, turns on CRC generation on outgoing packets while bit 5 is set.
// - The check-capable bit 7 resets to one and is writable only while unlocked.
// - Sticky enable bit 8, reset to zero, turns on CRC checking on received packets while bit 7 is set.
// - The header of the first reported uncorrectable error is held in four sticky log words.
//
// Chosen here: the plain strobed port.
`include "cerr_defs.svh"
`timescale 1ns/100ps

module cerr_regs (
    // Clock and resets
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   hot_rst,
    // Register port
    input  wire cerr_pkg::cerr_bus_t    bus,
    output logic [31:0]                 rdata,
    // Error sources
    input  wire cerr_pkg::cerr_event_t  events,
    input  wire cerr_pkg::cerr_unc_t    unc,
    input  wire logic                   unc_rearm,
    input  wire logic                   reg_lock,
    // Upstream report and CRC datapath controls
    output logic                        cor_report,
    output logic                        irq,
    output logic                        crc_gen_on,
    output logic                        crc_chk_on
);
    import cerr_pkg::*;

    logic [31:0]  status;
    logic [31:0]  mask;
    logic [4:0]   first_error_pointer;
    logic         crc_generation_capable;
    logic         crc_generation_enable;
    logic         crc_check_capable;
    logic         crc_check_enable;
    logic [127:0] header_log;
    logic         log_held;
    logic [31:0]  event_bits;
    logic [31:0]  next_status;
    logic [31:0]  next_mask;
    logic         wr_status;
    logic         wr_mask;
    logic         wr_control;

    // Places each event pulse at its status bit position.
    function automatic logic [31:0] event_vector(input cerr_event_t ev);
        logic [31:0] v;
        v                       = 32'h0000_0000;
        v[`CERR_BIT_RECEIVER]   = ev.receiver_fault_flag;
        v[`CERR_BIT_BAD_TLP]    = ev.bad_packet_flag;
        v[`CERR_BIT_BAD_DLLP]   = ev.bad_link_packet_flag;
        v[`CERR_BIT_ROLLOVER]   = ev.replay_rollover_flag;
        v[`CERR_BIT_TIMEOUT]    = ev.replay_timeout_flag;
        v[`CERR_BIT_ADVISORY]   = ev.advisory_flag;
        return v;
    endfunction

    assign event_bits = event_vector(events);
    assign wr_status  = bus.wr && (bus.addr == `CERR_OFF_STATUS);
    assign wr_mask    = bus.wr && (bus.addr == `CERR_OFF_MASK);
    assign wr_control = bus.wr && (bus.addr == `CERR_OFF_CONTROL);

    // A set in the same cycle as a clearing write wins, so no event is lost.
    always_comb begin
        next_status = status;
        if (wr_status) begin
            next_status = status & ~bus.wdata;
        end
        next_status = (next_status | event_bits) & `CERR_IMPL_MASK;
    end

    always_comb begin
        next_mask = mask;
        if (wr_mask) begin
            next_mask = bus.wdata & `CERR_IMPL_MASK;
        end
    end

    // Sticky status: hot reset is deliberately not looked at here.
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= `CERR_STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask <= `CERR_MASK_RESET;
        end else begin
            mask <= next_mask;
        end
    end

    // Upstream report is a pulse for any unmasked event of this cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            cor_report <= 1'b0;
        end else begin
            cor_report <= |(event_bits & ~mask);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & ~mask);
        end
    end

    // The capable bits are not sticky; locked writes leave them as they are.
    always_ff @(posedge clk) begin
        if (rst || hot_rst) begin
            crc_generation_capable <= `CERR_CAP_RESET;
            crc_check_capable      <= `CERR_CAP_RESET;
        end else if (wr_control && !reg_lock) begin
            crc_generation_capable <= bus.wdata[`CERR_BIT_GEN_CAP];
            crc_check_capable      <= bus.wdata[`CERR_BIT_CHK_CAP];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            crc_generation_enable <= `CERR_EN_RESET;
            crc_check_enable      <= `CERR_EN_RESET;
        end else if (wr_control) begin
            crc_generation_enable <= bus.wdata[`CERR_BIT_GEN_EN];
            crc_check_enable      <= bus.wdata[`CERR_BIT_CHK_EN];
        end
    end

    // Enables act only while the matching capability is present.
    always_ff @(posedge clk) begin
        if (rst) begin
            crc_gen_on <= 1'b0;
            crc_chk_on <= 1'b0;
        end else begin
            crc_gen_on <= crc_generation_enable && crc_generation_capable;
            crc_chk_on <= crc_check_enable && crc_check_capable;
        end
    end

    // Only the first report is kept; later ones are dropped until the owner rearms.
    always_ff @(posedge clk) begin
        if (rst) begin
            log_held            <= 1'b0;
            first_error_pointer <= `CERR_FEP_RESET;
            header_log          <= 128'h0;
        end else if (unc.valid && !log_held) begin
            log_held            <= 1'b1;
            first_error_pointer <= unc.bit_pos;
            header_log          <= unc.header;
        end else if (unc_rearm) begin
            log_held <= 1'b0;
        end
    end

    // Read data stand one cycle after the strobe; unmapped words read zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `CERR_OFF_STATUS:  rdata <= status;
                `CERR_OFF_MASK:    rdata <= mask;
                `CERR_OFF_CONTROL: rdata <= {23'h0, crc_check_enable, crc_check_capable,
                                             crc_generation_enable, crc_generation_capable,
                                             first_error_pointer};
                `CERR_OFF_HDR0:    rdata <= header_log[31:0];
                `CERR_OFF_HDR1:    rdata <= header_log[63:32];
                `CERR_OFF_HDR2:    rdata <= header_log[95:64];
                `CERR_OFF_HDR3:    rdata <= header_log[127:96];
                default:           rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_receiver_sets: assert property (
        events.receiver_fault_flag |=> status[`CERR_BIT_RECEIVER])
        else $error("Receiver fault did not set its status bit.");

    chk_bad_tlp_sets: assert property (
        events.bad_packet_flag |=> status[`CERR_BIT_BAD_TLP])
        else $error("Bad packet did not set its status bit.");

    chk_bad_dllp_sets: assert property (
        events.bad_link_packet_flag |=> status[`CERR_BIT_BAD_DLLP])
        else $error("Bad link packet did not set its status bit.");

    chk_rollover_sets: assert property (
        events.replay_rollover_flag |=> status[`CERR_BIT_ROLLOVER])
        else $error("Replay rollover did not set its status bit.");

    chk_timeout_sets: assert property (
        events.replay_timeout_flag |=> status[`CERR_BIT_TIMEOUT])
        else $error("Replay timeout did not set its status bit.");

    chk_advisory_sets: assert property (
        events.advisory_flag |=> status[`CERR_BIT_ADVISORY])
        else $error("Advisory error did not set its status bit.");

    chk_status_sticky_hold: assert property (
        (status[`CERR_BIT_RECEIVER] && !wr_status) |=> status[`CERR_BIT_RECEIVER])
        else $error("Receiver status bit fell without a clearing write.");

    chk_status_reserved_zero: assert property (
        (status & ~`CERR_IMPL_MASK) == 32'h0)
        else $error("Reserved status bit is set.");

    chk_w1c_clears: assert property (
        (wr_status && bus.wdata[`CERR_BIT_TIMEOUT] && !events.replay_timeout_flag)
        |=> !status[`CERR_BIT_TIMEOUT])
        else $error("Written one did not clear the timeout status bit.");

    chk_masked_no_report: assert property (
        ((event_bits & ~mask) == 32'h0) |=> !cor_report)
        else $error("Report raised for masked events only.");

    chk_unmasked_report: assert property (
        (events.bad_packet_flag && !mask[`CERR_BIT_BAD_TLP])
        |=> cor_report && status[`CERR_BIT_BAD_TLP])
        else $error("Unmasked bad packet not reported.");

    chk_advisory_mask_reset: assert property (
        $fell(rst) |-> mask == `CERR_MASK_RESET)
        else $error("Mask did not come out of reset with only the advisory bit.");

    chk_pointer_capture: assert property (
        (unc.valid && !log_held) |=> first_error_pointer == $past(unc.bit_pos) ##0
        header_log == $past(unc.header))
        else $error("First error pointer or header log not captured.");

    chk_log_holds: assert property (
        log_held |=> $stable(header_log) && $stable(first_error_pointer))
        else $error("Header log changed while held.");

    chk_lock_cap_gen: assert property (
        (wr_control && reg_lock && !hot_rst) |=> $stable(crc_generation_capable))
        else $error("Generation capable bit changed while locked.");

    chk_lock_cap_chk: assert property (
        (wr_control && reg_lock && !hot_rst) |=> $stable(crc_check_capable))
        else $error("Check capable bit changed while locked.");

    chk_gen_enable_out: assert property (
        (wr_control && bus.wdata[`CERR_BIT_GEN_EN] && (hot_rst
         || (reg_lock ? crc_generation_capable : bus.wdata[`CERR_BIT_GEN_CAP])))
        |=> ##1 crc_gen_on)
        else $error("Generation enable did not reach the datapath.");

    chk_chk_enable_out: assert property (
        (wr_control && bus.wdata[`CERR_BIT_CHK_EN] && (hot_rst
         || (reg_lock ? crc_check_capable : bus.wdata[`CERR_BIT_CHK_CAP])))
        |=> ##1 crc_chk_on)
        else $error("Check enable did not reach the datapath.");

    chk_hot_keeps_sticky: assert property (
        (hot_rst && !wr_status && !wr_mask) |=> ($past(status) & ~status) == 32'h0
        && mask == $past(mask))
        else $error("Hot reset disturbed sticky bits.");

    chk_status_no_drop: assert property (
        !wr_status |=> ($past(status) & ~status) == 32'h0)
        else $error("Status bit fell without a clearing write.");

    chk_status_needs_event: assert property (
        1'b1 |=> (status & ~$past(status) & ~$past(event_bits)) == 32'h0)
        else $error("Status bit rose without an event.");

    chk_clear_collision: assert property (
        (wr_status && bus.wdata[`CERR_BIT_RECEIVER] && events.receiver_fault_flag)
        |=> status[`CERR_BIT_RECEIVER])
        else $error("Clearing write beat a same-cycle receiver fault.");

    chk_mask_reserved_zero: assert property (
        (mask & ~`CERR_IMPL_MASK) == 32'h0)
        else $error("Reserved mask bit is set.");

    chk_mask_only_written: assert property (
        !wr_mask |=> $stable(mask))
        else $error("Mask changed without a write.");

    chk_mask_write_lands: assert property (
        wr_mask |=> mask == ($past(bus.wdata) & `CERR_IMPL_MASK))
        else $error("Mask write did not land.");

    chk_irq_follows: assert property (
        1'b1 |=> irq == |($past(status) & ~$past(mask)))
        else $error("Interrupt does not follow unmasked status.");

    chk_report_needs_event: assert property (
        cor_report |-> $past(|(event_bits & ~mask)))
        else $error("Report raised without an unmasked event.");

    chk_hot_sets_gen_cap: assert property (
        hot_rst |=> crc_generation_capable)
        else $error("Hot reset did not restore the generation capable bit.");

    chk_hot_sets_chk_cap: assert property (
        hot_rst |=> crc_check_capable)
        else $error("Hot reset did not restore the check capable bit.");

    chk_unlocked_cap_write: assert property (
        (wr_control && !reg_lock && !hot_rst)
        |=> crc_generation_capable == $past(bus.wdata[`CERR_BIT_GEN_CAP]))
        else $error("Unlocked write to the generation capable bit did not land.");

    chk_gen_en_sticky: assert property (
        (hot_rst && !wr_control)
        |=> $stable(crc_generation_enable))
        else $error("Hot reset disturbed the generation enable.");

    chk_chk_en_sticky: assert property (
        (hot_rst && !wr_control)
        |=> $stable(crc_check_enable))
        else $error("Hot reset disturbed the check enable.");

    chk_gen_on_gated: assert property (
        crc_gen_on |-> $past(crc_generation_enable && crc_generation_capable))
        else $error("Generation output on without enable and capability.");

    chk_chk_on_gated: assert property (
        crc_chk_on |-> $past(crc_check_enable && crc_check_capable))
        else $error("Check output on without enable and capability.");

    chk_pointer_read_only: assert property (
        !(unc.valid && !log_held) |=> $stable(first_error_pointer))
        else $error("First error pointer changed without a capture.");

    chk_log_rearm_frees: assert property (
        (unc_rearm && !unc.valid)
        |=> !log_held)
        else $error("Rearm did not release the header log.");

    chk_status_readback: assert property (
        (bus.rd && bus.addr == `CERR_OFF_STATUS)
        |=> rdata == $past(status))
        else $error("Status read returned wrong data.");

    chk_log_readback: assert property (
        (bus.rd && bus.addr == `CERR_OFF_HDR0)
        |=> rdata == $past(header_log[31:0]))
        else $error("First header log word read returned wrong data.");

    cov_clear_collision: cover property (
        wr_status && bus.wdata[`CERR_BIT_RECEIVER] && events.receiver_fault_flag);

    cov_irq_rise: cover property ($rose(irq));

    cov_masked_event: cover property (events.advisory_flag && mask[`CERR_BIT_ADVISORY]);

    cov_log_rearm: cover property (log_held ##1 unc_rearm ##1 !log_held);

    cov_locked_write: cover property (wr_control && reg_lock);

endmodule // cerr_regs

// ### include/cerr_defs.svh
// Offsets, field positions and reset values of the correctable error report registers.
// Assumes a 12-bit byte address from a plain register port on one core clock.
`ifndef CERR_DEFS_SVH
`define CERR_DEFS_SVH

`define CERR_ADDR_W          12
`define CERR_OFF_STATUS      12'h110
`define CERR_OFF_MASK        12'h114
`define CERR_OFF_CONTROL     12'h118
`define CERR_OFF_HDR0        12'h11c
`define CERR_OFF_HDR1        12'h120
`define CERR_OFF_HDR2        12'h124
`define CERR_OFF_HDR3        12'h128

`define CERR_BIT_RECEIVER    0
`define CERR_BIT_BAD_TLP     6
`define CERR_BIT_BAD_DLLP    7
`define CERR_BIT_ROLLOVER    8
`define CERR_BIT_TIMEOUT     12
`define CERR_BIT_ADVISORY    13
`define CERR_IMPL_MASK       32'h0000_31c1

`define CERR_STATUS_RESET    32'h0000_0000
`define CERR_MASK_RESET      32'h0000_2000

`define CERR_FEP_LSB         0
`define CERR_FEP_MSB         4
`define CERR_BIT_GEN_CAP     5
`define CERR_BIT_GEN_EN      6
`define CERR_BIT_CHK_CAP     7
`define CERR_BIT_CHK_EN      8
`define CERR_FEP_RESET       5'h00
`define CERR_CAP_RESET       1'h1
`define CERR_EN_RESET        1'h0

`endif

// ### include/cerr_pkg.sv
// Types shared by the correctable error report registers.
// Assumes the constants header is compiled alongside it.
package cerr_pkg;

    // One-cycle event pulses from the link and transaction layers.
    typedef struct packed {
        logic receiver_fault_flag;
        logic bad_packet_flag;
        logic bad_link_packet_flag;
        logic replay_rollover_flag;
        logic replay_timeout_flag;
        logic advisory_flag;
    } cerr_event_t;

    // First uncorrectable error report from the uncorrectable status logic.
    typedef struct packed {
        logic         valid;
        logic [4:0]   bit_pos;
        logic [127:0] header;
    } cerr_unc_t;

    // Register port request.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cerr_bus_t;

endpackage

// ### sim/cerr_root_model.sv
// Behavioural stand-in for the root complex that receives correctable error reports.
// Assumes cor_report is a one-cycle pulse on the core clock.
`timescale 1ns/100ps

module cerr_root_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Report from the port
    input  wire logic cor_report,
    output int        report_count
);
    // Every high cycle counts as one message, so a report that sticks high shows up as extras.
    always_ff @(posedge clk) begin
        if (rst) begin
            report_count <= 0;
        end else if (cor_report) begin
            report_count <= report_count + 1;
        end
    end
endmodule // cerr_root_model

// ### sim/testbench.sv
// Self-checking bench for the correctable error report registers.
// Assumes reads answer one cycle later and error events are one-cycle pulses.
`include "cerr_defs.svh"
`timescale 1ns/100ps

module testbench;
    import cerr_pkg::*;

    localparam int pos [6] = '{0, 6, 7, 8, 12, 13};
    logic        clk;
    logic        rst;
    logic        hot_rst;
    cerr_bus_t   bus;
    logic [31:0] rdata;
    cerr_event_t events;
    cerr_unc_t   unc;
    logic        unc_rearm;
    logic        reg_lock;
    logic        cor_report;
    logic        irq;
    logic        crc_gen_on;
    logic        crc_chk_on;
    int          report_count;
    int          base;
    int          fails;
    int          total_checks;
    int          cycles;
    logic [31:0] data;

    cerr_regs cerr_regs_i (.clk(clk), .rst(rst), .hot_rst(hot_rst), .bus(bus), .rdata(rdata),
        .events(events), .unc(unc), .unc_rearm(unc_rearm), .reg_lock(reg_lock),
        .cor_report(cor_report), .irq(irq), .crc_gen_on(crc_gen_on), .crc_chk_on(crc_chk_on));
    cerr_root_model cerr_root_model_i (.clk(clk), .rst(rst), .cor_report(cor_report),
        .report_count(report_count));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hang would otherwise never reach the verdict.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            $display("CHECK FAILED at %0t: timeout", $time);
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_write(input logic [11:0] addr, input logic [31:0] wdata);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: wdata};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic read_check(input logic [11:0] addr, input logic [31:0] exp, input string what);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0};
        @(posedge clk);
        bus <= '0;
        #1 check(rdata, exp, what);
    endtask

    task automatic pulse_event(input logic [5:0] ev);
        @(posedge clk);
        events <= cerr_event_t'(ev);
        @(posedge clk);
        events <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        rst = 1'b1;
        hot_rst = 1'b0;
        bus = '0;
        events = '0;
        unc = '0;
        unc_rearm = 1'b0;
        reg_lock = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        read_check(`CERR_OFF_STATUS, 32'h0, "status reset");
        read_check(`CERR_OFF_MASK, 32'h0000_2000, "mask reset");
        read_check(`CERR_OFF_CONTROL, 32'h0000_00a0, "control reset");
        read_check(12'h200, 32'h0, "unmapped read");
        // The advisory event comes last, while its mask bit still holds its reset value.
        for (int i = 0; i < 6; i++) begin
            base = report_count;
            pulse_event(6'h20 >> i);
            read_check(`CERR_OFF_STATUS, 32'h1 << pos[i], "event");
            check(32'(report_count - base), (i == 5) ? 32'h0 : 32'h1, "reports");
            reg_write(`CERR_OFF_STATUS, 32'hffff_ffff);
            read_check(`CERR_OFF_STATUS, 32'h0, "write one clears");
        end
        reg_write(`CERR_OFF_MASK, 32'hffff_ffff);
        read_check(`CERR_OFF_MASK, `CERR_IMPL_MASK, "mask write");
        base = report_count;
        pulse_event(6'h10);
        check({31'h0, irq}, 32'h0, "irq masked");
        check(32'(report_count - base), 32'h0, "masked report");
        read_check(`CERR_OFF_STATUS, 32'h0000_0040, "masked status");
        reg_write(`CERR_OFF_MASK, 32'h0);
        settle();
        check({31'h0, irq}, 32'h1, "irq unmasked");
        reg_write(`CERR_OFF_STATUS, 32'h0000_0040);
        settle();
        check({31'h0, irq}, 32'h0, "irq cleared");
        // An event in the same cycle as the clearing write of its bit must not be lost.
        @(posedge clk);
        bus    <= '{wr: 1'b1, rd: 1'b0, addr: `CERR_OFF_STATUS, wdata: 32'h1};
        events <= cerr_event_t'(6'h20);
        @(posedge clk);
        bus    <= '0;
        events <= '0;
        read_check(`CERR_OFF_STATUS, 32'h1, "set beats clear");
        @(posedge clk);
        #1 check(rdata, 32'h0, "read data drops");
        reg_write(`CERR_OFF_CONTROL, 32'h0000_01e0);
        settle();
        check({30'h0, crc_gen_on, crc_chk_on}, 32'h3, "crc on");
        reg_lock <= 1'b1;
        reg_write(`CERR_OFF_CONTROL, 32'h0000_001f);
        read_check(`CERR_OFF_CONTROL, 32'h0000_00a0, "locked write");
        reg_lock <= 1'b0;
        reg_write(`CERR_OFF_CONTROL, 32'h0000_0140);
        settle();
        check({30'h0, crc_gen_on, crc_chk_on}, 32'h0, "not capable");
        // Capable bits stay cleared here so that the hot reset has something to restore.
        pulse_event(6'h20);
        @(posedge clk);
        hot_rst <= 1'b1;
        @(posedge clk);
        hot_rst <= 1'b0;
        read_check(`CERR_OFF_STATUS, 32'h1, "sticky status");
        read_check(`CERR_OFF_CONTROL, 32'h0000_01e0, "sticky enables");
        // A second report before rearm must not overwrite the first one.
        @(posedge clk);
        unc <= '{valid: 1'b1, bit_pos: 5'h04, header: {32'h4444_0004, 32'h3333_0003,
                 32'h2222_0002, 32'h1111_0001}};
        @(posedge clk);
        unc <= '{valid: 1'b1, bit_pos: 5'h09, header: '1};
        @(posedge clk);
        unc <= '0;
        read_check(`CERR_OFF_CONTROL, 32'h0000_01e4, "pointer");
        for (int k = 0; k < 4; k++) begin
            read_check(12'(`CERR_OFF_HDR0 + 4 * k), 32'(32'h11110001 * (k + 1)), "log");
        end
        @(posedge clk);
        unc_rearm <= 1'b1;
        @(posedge clk);
        unc_rearm <= 1'b0;
        unc <= '{valid: 1'b1, bit_pos: 5'h0b, header: '0};
        @(posedge clk);
        unc <= '0;
        read_check(`CERR_OFF_CONTROL, 32'h0000_01eb, "rearmed pointer");
        print_verdict();
    end
endmodule // testbench
